// [adcrt_defines.svh]
`ifndef ADCRT_DEFINES_SVH
`define ADCRT_DEFINES_SVH

// Clock
`define ADCRT_CLK_NS 4

// Register byte offsets
`define ADCRT_OFF_CTRL   12'h000
`define ADCRT_OFF_STATUS 12'h004
`define ADCRT_OFF_RESULT 12'h008
`define ADCRT_OFF_FIFO   12'h00C

// Control field positions
`define ADCRT_CTRL_SPEED_LSB 0
`define ADCRT_CTRL_IFACE_LSB 2
`define ADCRT_CTRL_DIV_LSB   4
`define ADCRT_CTRL_FIFOEN    6

// Status field positions
`define ADCRT_STAT_BUSY      0
`define ADCRT_STAT_EMPTY     1
`define ADCRT_STAT_FULL      2
`define ADCRT_STAT_DROP      3
`define ADCRT_STAT_LEVEL_LSB 8

// Reset values
`define ADCRT_CTRL_RESET 7'h00

// Conversion times per speed
`define ADCRT_CONV_FAST_NS 750
`define ADCRT_CONV_NORM_NS 1000
`define ADCRT_CONV_LOWP_NS 1250
`define ADCRT_CONV_OVERHEAD_CYC 4

// Busy edges
`define ADCRT_BUSY_RISE_NS 35
`define ADCRT_EOC_BUSY_NS  10
`define ADCRT_DATA_BUSY_NS 12
`define ADCRT_SYNC_BUSY_NS 25

// Frame sync delay in read during convert
`define ADCRT_SYNC_FAST_NS 25
`define ADCRT_SYNC_NORM_NS 275
`define ADCRT_SYNC_LOWP_NS 525

// Serial clock periods
`define ADCRT_SCLK_RDC_NS  32
`define ADCRT_SCLK_DIV0_NS 32
`define ADCRT_SCLK_DIV1_NS 56
`define ADCRT_SCLK_DIV2_NS 104
`define ADCRT_SCLK_DIV3_NS 200

// Last clock edge to frame sync release
`define ADCRT_SEND_RDC_NS  3
`define ADCRT_SEND_DIV0_NS 3
`define ADCRT_SEND_DIV1_NS 55
`define ADCRT_SEND_DIV2_NS 130
`define ADCRT_SEND_DIV3_NS 290

`endif

// [adcrt_pkg.sv]
package adcrt_pkg;

  typedef enum logic [1:0] {
    ADCRT_FAST   = 2'h0,
    ADCRT_NORMAL = 2'h1,
    ADCRT_LOWPWR = 2'h2
  } adcrt_speed_t;

  typedef enum logic [1:0] {
    ADCRT_PAR     = 2'h0,
    ADCRT_SER_RDC = 2'h1,
    ADCRT_SER_RAC = 2'h2
  } adcrt_iface_t;

  typedef struct packed {
    logic         fifo_en;
    logic [1:0]   serial_clock_divider_sel;
    adcrt_iface_t iface;
    adcrt_speed_t speed;
  } adcrt_ctrl_t;

  typedef struct packed {
    logic sync;
    logic sclk;
    logic sdo;
  } adcrt_ser_t;

  typedef enum logic [2:0] {
    ADCRT_C_IDLE  = 3'h0,
    ADCRT_C_CONV  = 3'h1,
    ADCRT_C_TAIL  = 3'h3,
    ADCRT_C_XFER  = 3'h2,
    ADCRT_C_BTAIL = 3'h6
  } adcrt_cst_t;

  typedef enum logic [1:0] {
    ADCRT_S_IDLE  = 2'h0,
    ADCRT_S_DLY   = 2'h1,
    ADCRT_S_SHIFT = 2'h3,
    ADCRT_S_END   = 2'h2
  } adcrt_sst_t;

endpackage

// [adcrt_fifo.sv]
`timescale 1ns/10ps
`default_nettype none

module adcrt_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // Fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // Drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // Fill level
  output logic [$clog2(DEPTH):0]        level
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
      $error("adcrt_fifo needs a power of two depth of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } adcrt_fifo_st_t;

  adcrt_fifo_st_t st_r;
  adcrt_fifo_st_t st_nxt;
  logic           push;
  logic           pop;

  assign in_ready  = st_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_r.cnt != '0;
  assign out_data  = st_r.mem[st_r.rp];
  assign level     = st_r.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp           = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    case ({push, pop})
      2'b10:   st_nxt.cnt = st_r.cnt + 1'b1;
      2'b01:   st_nxt.cnt = st_r.cnt - 1'b1;
      default: st_nxt.cnt = st_r.cnt;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

`default_nettype wire

// [adcrt_top.sv]
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "adcrt_defines.svh"

module adcrt_top #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Converter core result
  input  wire logic [15:0] CORE_RESULT,
  // Conversion control
  input  wire logic        CONVERSION_TRIGGER_N,
  input  wire logic        CS_N,
  output logic             BUSY,
  // Parallel result bus
  output logic [15:0]      DATA_OUT,
  output logic             DATA_OE,
  // Serial master port
  output logic             SYNC_OUT,
  output logic             SYNC_OE,
  output logic             SCLK_OUT,
  output logic             SCLK_OE,
  output logic             SERIAL_RESULT_OUT,
  output logic             SERIAL_RESULT_OE
);

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  generate
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128) begin : g_bad_depth
      $error("adcrt_top needs a result buffer depth from 2 to 128");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Derived cycle counts

  localparam int TAIL_EOC  = (`ADCRT_EOC_BUSY_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS;
  localparam int TAIL_DATA = (`ADCRT_DATA_BUSY_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS;
  localparam int TAIL_CYC  = (TAIL_EOC > TAIL_DATA) ? TAIL_EOC : TAIL_DATA;
  localparam int SBUSY_CYC = `ADCRT_SYNC_BUSY_NS / `ADCRT_CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = addr == off;
  endfunction

  function automatic logic [8:0] conv_cycles(input adcrt_pkg::adcrt_speed_t s);
    case (s)
      adcrt_pkg::ADCRT_FAST: begin
        conv_cycles = 9'(`ADCRT_CONV_FAST_NS / `ADCRT_CLK_NS - `ADCRT_CONV_OVERHEAD_CYC);
      end
      adcrt_pkg::ADCRT_NORMAL: begin
        conv_cycles = 9'(`ADCRT_CONV_NORM_NS / `ADCRT_CLK_NS - `ADCRT_CONV_OVERHEAD_CYC);
      end
      default: begin
        conv_cycles = 9'(`ADCRT_CONV_LOWP_NS / `ADCRT_CLK_NS - `ADCRT_CONV_OVERHEAD_CYC);
      end
    endcase
  endfunction

  function automatic logic [8:0] sync_delay(input adcrt_pkg::adcrt_speed_t s);
    case (s)
      adcrt_pkg::ADCRT_FAST:   sync_delay = 9'(`ADCRT_SYNC_FAST_NS / `ADCRT_CLK_NS);
      adcrt_pkg::ADCRT_NORMAL: sync_delay = 9'(`ADCRT_SYNC_NORM_NS / `ADCRT_CLK_NS);
      default:                 sync_delay = 9'(`ADCRT_SYNC_LOWP_NS / `ADCRT_CLK_NS);
    endcase
  endfunction

  function automatic logic [8:0] half_cycles(input adcrt_pkg::adcrt_ctrl_t c);
    if (c.iface != adcrt_pkg::ADCRT_SER_RAC) begin
      half_cycles = 9'(`ADCRT_SCLK_RDC_NS / (2 * `ADCRT_CLK_NS));
    end else begin
      case (c.serial_clock_divider_sel)
        2'h0:    half_cycles = 9'(`ADCRT_SCLK_DIV0_NS / (2 * `ADCRT_CLK_NS));
        2'h1:    half_cycles = 9'(`ADCRT_SCLK_DIV1_NS / (2 * `ADCRT_CLK_NS));
        2'h2:    half_cycles = 9'(`ADCRT_SCLK_DIV2_NS / (2 * `ADCRT_CLK_NS));
        default: half_cycles = 9'(`ADCRT_SCLK_DIV3_NS / (2 * `ADCRT_CLK_NS));
      endcase
    end
  endfunction

  function automatic logic [8:0] end_cycles(input adcrt_pkg::adcrt_ctrl_t c);
    if (c.iface != adcrt_pkg::ADCRT_SER_RAC) begin
      end_cycles = 9'((`ADCRT_SEND_RDC_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS);
    end else begin
      case (c.serial_clock_divider_sel)
        2'h0:    end_cycles = 9'((`ADCRT_SEND_DIV0_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS);
        2'h1:    end_cycles = 9'((`ADCRT_SEND_DIV1_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS);
        2'h2:    end_cycles = 9'((`ADCRT_SEND_DIV2_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS);
        default: end_cycles = 9'((`ADCRT_SEND_DIV3_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS);
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    adcrt_pkg::adcrt_cst_t  cst;
    adcrt_pkg::adcrt_sst_t  sst;
    adcrt_pkg::adcrt_ctrl_t ctrl;
    adcrt_pkg::adcrt_ctrl_t act;
    adcrt_pkg::adcrt_ser_t  ser;
    logic                   trig_d;
    logic                   busy;
    logic                   drop;
    logic [8:0]             ccnt;
    logic [8:0]             scnt;
    logic [3:0]             bits;
    logic [15:0]            shreg;
    logic [15:0]            result;
    logic [15:0]            pdata;
    logic                   pdata_oe;
    logic                   ser_oe;
    logic [31:0]            prdata;
  } adcrt_st_t;

  adcrt_st_t   st_r;
  adcrt_st_t   st_nxt;
  logic        trig_fall;
  logic        apb_setup;
  logic        apb_access;
  logic        mapped;
  logic        fifo_push;
  logic        fifo_pop;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic [31:0] rd_word;

  assign trig_fall  = st_r.trig_d & ~CONVERSION_TRIGGER_N;
  assign apb_setup  = PSEL & ~PENABLE;
  assign apb_access = PSEL & PENABLE;
  assign mapped     = hit(PADDR, `ADCRT_OFF_CTRL) | hit(PADDR, `ADCRT_OFF_STATUS) |
                      hit(PADDR, `ADCRT_OFF_RESULT) | hit(PADDR, `ADCRT_OFF_FIFO);

  assign PREADY  = 1'b1;
  assign PSLVERR = apb_access & ~mapped;
  assign PRDATA  = st_r.prdata;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(PADDR, `ADCRT_OFF_CTRL)) begin
      rd_word[`ADCRT_CTRL_FIFOEN:0] = st_r.ctrl;
    end else if (hit(PADDR, `ADCRT_OFF_STATUS)) begin
      rd_word[`ADCRT_STAT_BUSY]  = st_r.busy;
      rd_word[`ADCRT_STAT_EMPTY] = ~fifo_out_valid;
      rd_word[`ADCRT_STAT_FULL]  = ~fifo_in_ready;
      rd_word[`ADCRT_STAT_DROP]  = st_r.drop;
      rd_word[`ADCRT_STAT_LEVEL_LSB +: LW] = fifo_level;
    end else if (hit(PADDR, `ADCRT_OFF_RESULT)) begin
      rd_word[15:0] = st_r.result;
    end else if (hit(PADDR, `ADCRT_OFF_FIFO)) begin
      rd_word[15:0] = fifo_out_valid ? fifo_out_data : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt    = st_r;
    fifo_push = 1'b0;
    fifo_pop  = 1'b0;
    st_nxt.trig_d = CONVERSION_TRIGGER_N;

    // Output enables follow chip select and interface mode
    st_nxt.pdata_oe = ~CS_N & (st_r.ctrl.iface == adcrt_pkg::ADCRT_PAR);
    st_nxt.ser_oe   = ~CS_N & (st_r.ctrl.iface == adcrt_pkg::ADCRT_SER_RDC ||
                               st_r.ctrl.iface == adcrt_pkg::ADCRT_SER_RAC);

    // APB
    if (apb_setup && !PWRITE) begin
      st_nxt.prdata = rd_word;
    end
    if (apb_access && PWRITE) begin
      if (hit(PADDR, `ADCRT_OFF_CTRL)) begin
        st_nxt.ctrl = adcrt_pkg::adcrt_ctrl_t'(PWDATA[`ADCRT_CTRL_FIFOEN:0]);
      end
      if (hit(PADDR, `ADCRT_OFF_STATUS) && PWDATA[`ADCRT_STAT_DROP]) begin
        st_nxt.drop = 1'b0;
      end
    end
    if (apb_access && !PWRITE && hit(PADDR, `ADCRT_OFF_FIFO)) begin
      fifo_pop = fifo_out_valid;
    end

    // Serial shifter, MSB first
    case (st_r.sst)
      adcrt_pkg::ADCRT_S_IDLE: begin
        st_nxt.ser = '0;
      end
      adcrt_pkg::ADCRT_S_DLY: begin
        if (st_r.scnt == 9'h000) begin
          st_nxt.ser.sync = 1'b1;
          st_nxt.ser.sdo  = st_r.shreg[15];
          st_nxt.scnt     = half_cycles(st_r.act) - 9'h001;
          st_nxt.bits     = 4'h0;
          st_nxt.sst      = adcrt_pkg::ADCRT_S_SHIFT;
        end else begin
          st_nxt.scnt = st_r.scnt - 9'h001;
        end
      end
      adcrt_pkg::ADCRT_S_SHIFT: begin
        if (st_r.scnt == 9'h000) begin
          st_nxt.scnt = half_cycles(st_r.act) - 9'h001;
          if (!st_r.ser.sclk) begin
            st_nxt.ser.sclk = 1'b1;
          end else begin
            st_nxt.ser.sclk = 1'b0;
            if (st_r.bits == 4'hF) begin
              st_nxt.scnt = end_cycles(st_r.act) - 9'h001;
              st_nxt.sst  = adcrt_pkg::ADCRT_S_END;
            end else begin
              st_nxt.bits    = st_r.bits + 4'h1;
              st_nxt.shreg   = {st_r.shreg[14:0], 1'b0};
              st_nxt.ser.sdo = st_r.shreg[14];
            end
          end
        end else begin
          st_nxt.scnt = st_r.scnt - 9'h001;
        end
      end
      adcrt_pkg::ADCRT_S_END: begin
        if (st_r.scnt == 9'h000) begin
          st_nxt.ser = '0;
          st_nxt.sst = adcrt_pkg::ADCRT_S_IDLE;
        end else begin
          st_nxt.scnt = st_r.scnt - 9'h001;
        end
      end
      default: begin
        st_nxt.ser = '0;
        st_nxt.sst = adcrt_pkg::ADCRT_S_IDLE;
      end
    endcase

    // Conversion sequencer
    case (st_r.cst)
      adcrt_pkg::ADCRT_C_IDLE: begin
        if (trig_fall) begin
          if (st_r.ctrl.fifo_en && !fifo_in_ready) begin
            st_nxt.drop = 1'b1;
          end else begin
            st_nxt.busy = 1'b1;
            st_nxt.act  = st_r.ctrl;
            st_nxt.ccnt = conv_cycles(st_r.ctrl.speed);
            st_nxt.cst  = adcrt_pkg::ADCRT_C_CONV;
            if (st_r.ctrl.iface == adcrt_pkg::ADCRT_SER_RDC) begin
              st_nxt.sst   = adcrt_pkg::ADCRT_S_DLY;
              st_nxt.scnt  = sync_delay(st_r.ctrl.speed);
              st_nxt.shreg = st_r.result;
            end
          end
        end
      end
      adcrt_pkg::ADCRT_C_CONV: begin
        if (st_r.ccnt == 9'h000) begin
          st_nxt.result = CORE_RESULT;
          fifo_push     = st_r.act.fifo_en;
          if (st_r.act.iface == adcrt_pkg::ADCRT_PAR) begin
            st_nxt.pdata = CORE_RESULT;
          end
          if (st_r.act.iface == adcrt_pkg::ADCRT_SER_RAC) begin
            st_nxt.sst   = adcrt_pkg::ADCRT_S_DLY;
            st_nxt.scnt  = 9'h000;
            st_nxt.shreg = CORE_RESULT;
            st_nxt.cst   = adcrt_pkg::ADCRT_C_XFER;
          end else begin
            st_nxt.ccnt = 9'(TAIL_CYC - 1);
            st_nxt.cst  = adcrt_pkg::ADCRT_C_TAIL;
          end
        end else begin
          st_nxt.ccnt = st_r.ccnt - 9'h001;
        end
      end
      adcrt_pkg::ADCRT_C_XFER: begin
        if (st_r.sst == adcrt_pkg::ADCRT_S_IDLE) begin
          st_nxt.ccnt = 9'(SBUSY_CYC - 2);
          st_nxt.cst  = adcrt_pkg::ADCRT_C_BTAIL;
        end
      end
      adcrt_pkg::ADCRT_C_TAIL, adcrt_pkg::ADCRT_C_BTAIL: begin
        if (st_r.ccnt == 9'h000) begin
          st_nxt.busy = 1'b0;
          st_nxt.cst  = adcrt_pkg::ADCRT_C_IDLE;
        end else begin
          st_nxt.ccnt = st_r.ccnt - 9'h001;
        end
      end
      default: begin
        st_nxt.busy = 1'b0;
        st_nxt.cst  = adcrt_pkg::ADCRT_C_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r      <= '0;
      st_r.ctrl <= adcrt_pkg::adcrt_ctrl_t'(`ADCRT_CTRL_RESET);
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result buffer

  adcrt_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .nrst      (NRST),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (CORE_RESULT),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  assign BUSY              = st_r.busy;
  assign DATA_OUT          = st_r.pdata;
  assign DATA_OE           = st_r.pdata_oe;
  assign SYNC_OUT          = st_r.ser.sync;
  assign SCLK_OUT          = st_r.ser.sclk;
  assign SERIAL_RESULT_OUT = st_r.ser.sdo;
  assign SYNC_OE           = st_r.ser_oe;
  assign SCLK_OE           = st_r.ser_oe;
  assign SERIAL_RESULT_OE  = st_r.ser_oe;

endmodule

`default_nettype wire

// [adcrt_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module adcrt_chk (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        NRST,
  // Watched pins
  input wire logic        CONVERSION_TRIGGER_N,
  input wire logic        CS_N,
  input wire logic        BUSY,
  input wire logic [15:0] DATA_OUT,
  input wire logic        DATA_OE,
  input wire logic        SYNC_OUT,
  input wire logic        SYNC_OE,
  input wire logic        SCLK_OUT,
  input wire logic        SCLK_OE,
  input wire logic        SERIAL_RESULT_OE
);
  typedef struct packed {
    logic [10:0] bcnt;
    logic        saw;
    logic [4:0]  bits;
    logic        sclk;
  } adcrt_chk_t;
  adcrt_chk_t st_r;
  adcrt_chk_t st_nxt;
  // Busy length, frame seen in busy, clock rises per frame
  always_comb begin
    st_nxt      = st_r;
    st_nxt.sclk = SCLK_OUT;
    st_nxt.bcnt = BUSY ? st_r.bcnt + 11'h001 : 11'h000;
    st_nxt.saw  = BUSY & (st_r.saw | SYNC_OUT);
    st_nxt.bits = SYNC_OUT ? st_r.bits + {4'h0, SCLK_OUT & ~st_r.sclk} : 5'h00;
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  sequence s_sclk_high;
    SCLK_OUT [*4];
  endsequence
  sequence s_sclk_drop;
    ##[1:32] !SCLK_OUT;
  endsequence
  property p_busy_cause;
    $rose(BUSY) |-> !$past(CONVERSION_TRIGGER_N) && $past(CONVERSION_TRIGGER_N, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without trigger");
  property p_busy_span;
    $fell(BUSY) && !st_r.saw |-> st_r.bcnt inside {[187:312]};
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("busy length wrong");
  property p_busy_cap;
    BUSY |-> st_r.bcnt < 1437;
  endproperty
  a_busy_cap: assert property (p_busy_cap) else $error("busy too long");
  property p_data_hold;
    $fell(BUSY) && DATA_OE |-> $stable(DATA_OUT) && DATA_OUT == $past(DATA_OUT, 3);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data late");
  property p_sclk_half;
    $rose(SCLK_OUT) |-> s_sclk_high ##0 s_sclk_drop;
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("clock half wrong");
  property p_frame_bits;
    $fell(SYNC_OUT) |-> st_r.bits == 5'h10;
  endproperty
  a_frame_bits: assert property (p_frame_bits) else $error("frame not 16 bits");
  property p_frame_in_busy;
    $rose(SYNC_OUT) |-> BUSY && $past(BUSY, 6);
  endproperty
  a_frame_in_busy: assert property (p_frame_in_busy) else $error("sync early");
  property p_busy_after_sync;
    $fell(SYNC_OUT) |-> BUSY [*4];
  endproperty
  a_busy_after_sync: assert property (p_busy_after_sync) else $error("busy early");
  property p_cs_release;
    CS_N |=> !SYNC_OE && !SCLK_OE && !SERIAL_RESULT_OE;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("pins not released");
endmodule
bind adcrt_top adcrt_chk u_chk (.CLK, .NRST, .CONVERSION_TRIGGER_N, .CS_N, .BUSY, .DATA_OUT,
  .DATA_OE, .SYNC_OUT, .SYNC_OE, .SCLK_OUT, .SCLK_OE, .SERIAL_RESULT_OE);
`default_nettype wire

// [adcrt_host_rx.sv]
`timescale 1ns/10ps
`default_nettype none
module adcrt_host_rx (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  nrst,
  // Serial pins
  input wire adcrt_pkg::adcrt_ser_t ser,
  input wire logic                  sync_oe,
  // Received frame
  output logic [15:0]               word,
  output logic                      done
);
  typedef struct packed {
    logic [15:0] sh;
    logic        sclk;
    logic        sync;
    logic        done;
  } adcrt_rx_t;
  adcrt_rx_t st_r;
  adcrt_rx_t st_nxt;
  always_comb begin
    st_nxt      = st_r;
    st_nxt.sclk = ser.sclk;
    st_nxt.sync = ser.sync & sync_oe;
    st_nxt.done = st_r.sync & ~st_nxt.sync;
    if (st_nxt.sync && ser.sclk && !st_r.sclk) begin
      st_nxt.sh = {st_r.sh[14:0], ser.sdo};
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign word = st_r.sh;
  assign done = st_r.done;
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] core;
  logic        trig_n;
  logic        cs_n;
  logic        busy;
  logic        busy_q;
  logic [15:0] dout;
  logic        doe;
  logic        sync_oe;
  logic        rx_done;
  logic [15:0] rx_word;
  logic [15:0] last;
  logic [15:0] expq[$];
  logic [15:0] held[16];
  logic [31:0] seed;
  logic [31:0] r;
  logic        e;
  int          fails;
  int          checks_done;
  int          w;
  int          bw[3] = '{187, 250, 312};
  int          lim[4] = '{375, 500, 750, 1312};
  adcrt_pkg::adcrt_ser_t ser;

  adcrt_top #(.FIFO_DEPTH(16)) DUT (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CORE_RESULT(core), .CONVERSION_TRIGGER_N(trig_n), .CS_N(cs_n),
    .BUSY(busy), .DATA_OUT(dout), .DATA_OE(doe), .SYNC_OUT(ser.sync), .SYNC_OE(sync_oe),
    .SCLK_OUT(ser.sclk), .SCLK_OE(), .SERIAL_RESULT_OUT(ser.sdo), .SERIAL_RESULT_OE());
  adcrt_host_rx u_rx (.clk(clk), .nrst(nrst), .ser(ser), .sync_oe(sync_oe),
    .word(rx_word), .done(rx_done));

  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic logic [31:0] cw(logic f, logic [1:0] d, adcrt_pkg::adcrt_iface_t i,
                                     logic [1:0] s);
    return {25'h000_0000, f, d, i, s};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic apb(input logic wt, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wt;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, d, x, y);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic        y;
    apb(1'b0, a, 32'h0000_0000, x, y);
    chk("apb read", x, exp);
  endtask
  // One trigger fall, plus a second one at busy cycle 40 when dbl is set; w gets the busy length in cycles
  task automatic conv(input logic [15:0] v, input bit dbl);
    int n;
    core <= v;
    trig_n <= 1'b0;
    @(posedge clk);
    trig_n <= 1'b1;
    n = 0;
    w = 0;
    while (busy !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    while (busy === 1'b1 && w < 2000) begin
      @(posedge clk);
      w++;
      if (dbl && w == 40) trig_n <= 1'b0;
      if (dbl && w == 42) trig_n <= 1'b1;
    end
    repeat (130) @(posedge clk);
  endtask
  task automatic take(input logic [15:0] v);
    logic [15:0] x;
    x = (expq.size() > 0) ? expq.pop_front() : 16'hxxxx;
    chk("result", {16'h0000, v}, {16'h0000, x});
  endtask
  // Result watcher
  always @(posedge clk) begin
    busy_q <= busy;
    if (rx_done === 1'b1) take(rx_word);
    if (busy_q === 1'b1 && busy === 1'b0 && doe === 1'b1) take(dout);
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h7fab_4adb;
    fails = 0;
    checks_done = 0;
    clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    core = 16'h0000;
    trig_n = 1'b1;
    cs_n = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(12'h000, 32'h0000_0000);
    rdc(12'h004, 32'h0000_0002);
    apb(1'b1, 12'h010, 32'hffff_ffff, r, e);
    chk("slverr", {31'h0000_0000, e}, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000, r, e);
    chk("unmapped", r, 32'h0000_0000);
    rdc(12'h000, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr(12'h000, cw(1'b0, 2'h0, adcrt_pkg::ADCRT_PAR, i[1:0]));
      last = rnd();
      expq.push_back(last);
      conv(last, i == 1);
      chk("busy width", w, bw[i]);
      rdc(12'h008, {16'h0000, last});
    end
    for (int d = 0; d < 4; d++) begin
      wr(12'h000, cw(1'b0, d[1:0], adcrt_pkg::ADCRT_SER_RAC, 2'h0));
      last = rnd();
      expq.push_back(last);
      conv(last, 1'b0);
      chk("rac busy", {31'h0000_0000, w <= lim[d]}, 32'h0000_0001);
    end
    for (int i = 0; i < 3; i++) begin
      wr(12'h000, cw(1'b0, 2'h0, adcrt_pkg::ADCRT_SER_RDC, i[1:0]));
      expq.push_back(last);
      last = rnd();
      conv(last, 1'b0);
      chk("rdc busy", w, bw[i]);
    end
    cs_n <= 1'b1;
    conv(rnd(), 1'b0);
    cs_n <= 1'b0;
    wr(12'h000, cw(1'b1, 2'h0, adcrt_pkg::ADCRT_PAR, 2'h0));
    for (int i = 0; i < 16; i++) begin
      held[i] = rnd();
      expq.push_back(held[i]);
      conv(held[i], 1'b0);
    end
    rdc(12'h004, 32'h0000_1004);
    conv(rnd(), 1'b0);
    chk("drop busy", w, 32'h0000_0000);
    rdc(12'h004, 32'h0000_100c);
    wr(12'h004, 32'h0000_0008);
    rdc(12'h004, 32'h0000_1004);
    for (int i = 0; i < 16; i++) begin
      repeat (i % 3) @(posedge clk);
      rdc(12'h00c, {16'h0000, held[i]});
    end
    rdc(12'h00c, 32'h0000_0000);
    rdc(12'h004, 32'h0000_0002);
    chk("results left", expq.size(), 32'h0000_0000);
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
